// file: rtl/mcd_pkg.sv
// Package of register map, field layout and timing constants for the missing clock detector
// Behaviour
// - Density input divider powered up while its control bit 7 is 1, down when 0.
// - Bitstream divider powered up while its control bit 7 is 1, down when 0.
// - Memory-reload bit 7 set restores processor memory defaults on restart; clear keeps contents.
// - Reload choice applies only after non-user shutdowns, never after user power down.
// - Detector one watches serial audio clock when bit 4 is 0, density clock when 1.
// - Detector two source 0 playback, 1 sense converter, 2 PLL clock, 3 reserved.
// - Detector one runs only while configuration bit 1 is set.
// - Detector two runs only while configuration bit 0 is set.
// - Timeout codes 0..7 give 11, 22, 44, 87, 174, 350, 700 ms and 1.2 s.
// - Detector one timeout in bits 5-3, detector two in bits 2-0.
// - Enabled detector whose clock stays absent for the timeout shuts the device down.
// - Clock-error shutdown sets a sticky flag; host clears it before powering up again.
package mcd_pkg;
	localparam logic [7:0] MCD_ADDR_DENSITY_DIV = 8'h1d;
	localparam logic [7:0] MCD_ADDR_BITSTREAM_DIV = 8'h1e;
	localparam logic [7:0] MCD_ADDR_DETECT_CFG = 8'h21;
	localparam logic [7:0] MCD_ADDR_TIMEOUT_CFG = 8'h22;
	localparam logic [7:0] MCD_RST_DENSITY_DIV = 8'h08;
	localparam logic [7:0] MCD_RST_BITSTREAM_DIV = 8'h08;
	localparam logic [7:0] MCD_RST_DETECT_CFG = 8'h03;
	localparam logic [7:0] MCD_RST_TIMEOUT_CFG = 8'h3f;
	localparam int MCD_BIT_DIV_POWER = 7;
	localparam int MCD_BIT_MEM_RELOAD = 7;
	localparam int MCD_BIT_ONE_SRC = 4;
	localparam int MCD_BIT_TWO_SRC_HI = 3;
	localparam int MCD_BIT_TWO_SRC_LO = 2;
	localparam int MCD_BIT_ONE_EN = 1;
	localparam int MCD_BIT_TWO_EN = 0;
	localparam int MCD_BIT_ONE_TIME_HI = 5;
	localparam int MCD_BIT_ONE_TIME_LO = 3;
	localparam int MCD_BIT_TWO_TIME_HI = 2;
	localparam int MCD_BIT_TWO_TIME_LO = 0;
	// Clock rate and tick base for the absence timers
	localparam int MCD_CLK_HZ = 20_000_000;
	localparam int MCD_TICK_US = 100;
	localparam int MCD_TICK_CYCLES = MCD_CLK_HZ / 1_000_000 * MCD_TICK_US;
	localparam int MCD_TIMER_W = 14;
	typedef logic [MCD_TIMER_W-1:0] mcd_ticks_t;
	// Timeouts in microseconds, as printed
	localparam int MCD_T0_US = 11_000;
	localparam int MCD_T1_US = 22_000;
	localparam int MCD_T2_US = 44_000;
	localparam int MCD_T3_US = 87_000;
	localparam int MCD_T4_US = 174_000;
	localparam int MCD_T5_US = 350_000;
	localparam int MCD_T6_US = 700_000;
	localparam int MCD_T7_US = 1_200_000;
	typedef enum logic [1:0] {
		MCD_SRC2_PLAYBACK = 2'b00,
		MCD_SRC2_SENSE = 2'b01,
		MCD_SRC2_PLL = 2'b10,
		MCD_SRC2_RESERVED = 2'b11
	} mcd_src2_t;
	typedef enum logic [1:0] {
		MCD_ST_RUN = 2'b00,
		MCD_ST_FAULT = 2'b01,
		MCD_ST_RESTART = 2'b10
	} mcd_state_t;
	// Timeout code to tick count (least time, rounded up)
	function automatic mcd_ticks_t mcd_timeout_ticks(input logic [2:0] code);
		int us;
		case (code)
			3'h0: us = MCD_T0_US;
			3'h1: us = MCD_T1_US;
			3'h2: us = MCD_T2_US;
			3'h3: us = MCD_T3_US;
			3'h4: us = MCD_T4_US;
			3'h5: us = MCD_T5_US;
			3'h6: us = MCD_T6_US;
			default: us = MCD_T7_US;
		endcase
		return mcd_ticks_t'((us + MCD_TICK_US - 1) / MCD_TICK_US);
	endfunction
endpackage

// file: rtl/mcd_det_if.sv
// Interface between the controller and one clock absence detector
`timescale 1ns/1ps
interface mcd_det_if;
	import mcd_pkg::*;
	logic enable;
	logic [2:0] timeout_code;
	logic clk_seen;
	logic tick;
	logic timed_out;
	modport ctrl (output enable, output timeout_code, output clk_seen, output tick, input timed_out);
	modport det (input enable, input timeout_code, input clk_seen, input tick, output timed_out);
endinterface

// file: rtl/mcd_absence_timer.sv
// Absence timer for one monitored clock
`timescale 1ns/1ps
module mcd_absence_timer
	import mcd_pkg::*;
(
	input wire logic core_clk, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	mcd_det_if.det det // Controller side
);
	mcd_ticks_t count_ff, nxt_count;
	logic fired_ff, nxt_fired;
	always_comb begin
		nxt_count = count_ff;
		nxt_fired = 1'b0;
		if (!det.enable || det.clk_seen) begin
			nxt_count = '0;
		end else if (det.tick) begin
			if (count_ff + 1'b1 >= mcd_timeout_ticks(det.timeout_code)) begin
				nxt_fired = 1'b1;
				nxt_count = '0;
			end else begin
				nxt_count = count_ff + 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			count_ff <= '0;
			fired_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			fired_ff <= nxt_fired;
		end
	end
	assign det.timed_out = fired_ff;
endmodule

// file: rtl/mcd_top.sv
// Missing clock supervisor with divider power controls and register port
`timescale 1ns/1ps
module mcd_top
	import mcd_pkg::*;
(
	input wire logic core_clk, // System clock, 20 MHz
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, registered
	input wire logic serial_audio_clock, // Monitored pin clock
	input wire logic density_modulated_clock, // Monitored pin clock
	input wire logic playback_mod_clock, // Monitored internal clock
	input wire logic sense_mod_clock, // Monitored internal clock
	input wire logic pll_clock, // Monitored internal clock
	input wire logic user_power_down, // User shutdown request pulse
	input wire logic other_fault, // Brownout, over-current, temp or voltage pulse
	input wire logic error_flag_clear, // Host clears sticky flag, pulse
	input wire logic power_up_req, // Host restart request pulse
	output logic density_divider_power, // Density divider powered
	output logic bitstream_divider_power, // Bitstream divider powered
	output logic clock_error_sticky_flag, // Sticky clock error
	output logic device_shutdown, // Device held shut down
	output logic memory_reload // Reload pulse on restart
);
	import mcd_pkg::*;
	logic [7:0] density_div_ff, nxt_density_div;
	logic [7:0] bitstream_div_ff, nxt_bitstream_div;
	logic [7:0] detect_cfg_ff, nxt_detect_cfg;
	logic [7:0] timeout_cfg_ff, nxt_timeout_cfg;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [4:0] sync1_ff, sync2_ff, prev_ff;
	logic [4:0] edge_seen;
	logic [$clog2(MCD_TICK_CYCLES)-1:0] div_ff, nxt_div;
	logic tick;
	mcd_state_t state_ff, nxt_state;
	logic sticky_ff, nxt_sticky;
	logic non_user_ff, nxt_non_user;
	logic reload_ff, nxt_reload;
	mcd_det_if det_one();
	mcd_det_if det_two();

	// Register port
	always_comb begin
		nxt_density_div = density_div_ff;
		nxt_bitstream_div = bitstream_div_ff;
		nxt_detect_cfg = detect_cfg_ff;
		nxt_timeout_cfg = timeout_cfg_ff;
		nxt_rdata = rdata_ff;
		if (reg_wr) begin
			case (reg_addr)
				MCD_ADDR_DENSITY_DIV: nxt_density_div = reg_wdata;
				MCD_ADDR_BITSTREAM_DIV: nxt_bitstream_div = reg_wdata;
				MCD_ADDR_DETECT_CFG: nxt_detect_cfg = reg_wdata;
				MCD_ADDR_TIMEOUT_CFG: nxt_timeout_cfg = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				MCD_ADDR_DENSITY_DIV: nxt_rdata = density_div_ff;
				MCD_ADDR_BITSTREAM_DIV: nxt_rdata = bitstream_div_ff;
				MCD_ADDR_DETECT_CFG: nxt_rdata = detect_cfg_ff;
				MCD_ADDR_TIMEOUT_CFG: nxt_rdata = timeout_cfg_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			density_div_ff <= MCD_RST_DENSITY_DIV;
			bitstream_div_ff <= MCD_RST_BITSTREAM_DIV;
			detect_cfg_ff <= MCD_RST_DETECT_CFG;
			timeout_cfg_ff <= MCD_RST_TIMEOUT_CFG;
			rdata_ff <= 8'h00;
		end else begin
			density_div_ff <= nxt_density_div;
			bitstream_div_ff <= nxt_bitstream_div;
			detect_cfg_ff <= nxt_detect_cfg;
			timeout_cfg_ff <= nxt_timeout_cfg;
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;
	assign density_divider_power = density_div_ff[MCD_BIT_DIV_POWER];
	assign bitstream_divider_power = bitstream_div_ff[MCD_BIT_DIV_POWER];

	// Two-stage synchronisers and edge detect on the second stage
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
			prev_ff <= 5'h00;
		end else begin
			sync1_ff <= {pll_clock, sense_mod_clock, playback_mod_clock, density_modulated_clock, serial_audio_clock};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end
	assign edge_seen = sync2_ff ^ prev_ff;

	// Time base tick
	always_comb begin
		if (div_ff == ($bits(div_ff))'(MCD_TICK_CYCLES - 1)) begin
			nxt_div = '0;
		end else begin
			nxt_div = div_ff + 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			div_ff <= '0;
		end else begin
			div_ff <= nxt_div;
		end
	end
	assign tick = (div_ff == ($bits(div_ff))'(MCD_TICK_CYCLES - 1));

	// Detector wiring
	always_comb begin
		det_one.enable = detect_cfg_ff[MCD_BIT_ONE_EN] && (state_ff == MCD_ST_RUN);
		det_two.enable = detect_cfg_ff[MCD_BIT_TWO_EN] && (state_ff == MCD_ST_RUN);
		det_one.timeout_code = timeout_cfg_ff[MCD_BIT_ONE_TIME_HI:MCD_BIT_ONE_TIME_LO];
		det_two.timeout_code = timeout_cfg_ff[MCD_BIT_TWO_TIME_HI:MCD_BIT_TWO_TIME_LO];
		det_one.tick = tick;
		det_two.tick = tick;
		det_one.clk_seen = detect_cfg_ff[MCD_BIT_ONE_SRC] ? edge_seen[1] : edge_seen[0];
		case (mcd_src2_t'(detect_cfg_ff[MCD_BIT_TWO_SRC_HI:MCD_BIT_TWO_SRC_LO]))
			MCD_SRC2_PLAYBACK: det_two.clk_seen = edge_seen[2];
			MCD_SRC2_SENSE: det_two.clk_seen = edge_seen[3];
			MCD_SRC2_PLL: det_two.clk_seen = edge_seen[4];
			default: det_two.clk_seen = 1'b1;
		endcase
	end
	mcd_absence_timer u_det_one (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.det(det_one.det)
	);
	mcd_absence_timer u_det_two (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.det(det_two.det)
	);

	// Shutdown and restart control
	always_comb begin
		nxt_state = state_ff;
		nxt_sticky = sticky_ff;
		nxt_non_user = non_user_ff;
		nxt_reload = 1'b0;
		if (error_flag_clear) begin
			nxt_sticky = 1'b0;
		end
		case (state_ff)
			MCD_ST_RUN: begin
				if (det_one.timed_out || det_two.timed_out) begin
					nxt_state = MCD_ST_FAULT;
					nxt_sticky = 1'b1;
					nxt_non_user = 1'b1;
				end else if (other_fault) begin
					nxt_state = MCD_ST_FAULT;
					nxt_non_user = 1'b1;
				end else if (user_power_down) begin
					nxt_state = MCD_ST_FAULT;
					nxt_non_user = 1'b0;
				end
			end
			MCD_ST_FAULT: begin
				if (power_up_req && !sticky_ff && !error_flag_clear) begin
					nxt_state = MCD_ST_RESTART;
				end
			end
			MCD_ST_RESTART: begin
				nxt_state = MCD_ST_RUN;
				nxt_reload = non_user_ff && detect_cfg_ff[MCD_BIT_MEM_RELOAD];
				nxt_non_user = 1'b0;
			end
			default: nxt_state = MCD_ST_RUN;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_ff <= MCD_ST_RUN;
			sticky_ff <= 1'b0;
			non_user_ff <= 1'b0;
			reload_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sticky_ff <= nxt_sticky;
			non_user_ff <= nxt_non_user;
			reload_ff <= nxt_reload;
		end
	end
	assign clock_error_sticky_flag = sticky_ff;
	assign device_shutdown = (state_ff != MCD_ST_RUN);
	assign memory_reload = reload_ff;
endmodule

// file: tb/mcd_top_properties.sv
// Concurrent checks on the missing clock detector ports
`timescale 1ns/1ps
module mcd_top_checker (
	input wire logic core_clk, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_addr, // Address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic error_flag_clear, // Flag clear
	input wire logic density_divider_power, // Divider power
	input wire logic bitstream_divider_power, // Divider power
	input wire logic clock_error_sticky_flag, // Sticky error
	input wire logic device_shutdown, // Shut down
	input wire logic memory_reload // Reload pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic reload_bit_ff;
	logic nxt_reload_bit;
	// Shadow of the reload choice
	always_comb begin
		nxt_reload_bit = reload_bit_ff;
		if (reg_wr && reg_addr == 8'h21) begin
			nxt_reload_bit = reg_wdata[7];
		end
	end
	always_ff @(posedge core_clk) begin
		reload_bit_ff <= rst_b ? nxt_reload_bit : 1'b0;
	end
	a_density_power_write: assert property (reg_wr && reg_addr == 8'h1d |=>
		density_divider_power == $past(reg_wdata[7])) else $error("density power not taken from write");
	a_bitstream_power_write: assert property (reg_wr && reg_addr == 8'h1e |=>
		bitstream_divider_power == $past(reg_wdata[7])) else $error("bitstream power not taken from write");
	a_density_power_hold: assert property (!(reg_wr && reg_addr == 8'h1d) |=>
		$stable(density_divider_power)) else $error("density power changed without write");
	a_power_readback: assert property (reg_rd && reg_addr == 8'h1e |=>
		reg_rdata[7] == $past(bitstream_divider_power)) else $error("power bit readback differs");
	a_sticky_holds: assert property (clock_error_sticky_flag && !error_flag_clear |=>
		clock_error_sticky_flag) else $error("sticky flag lost without clear");
	a_sticky_rise_shut: assert property ($rose(clock_error_sticky_flag) |->
		device_shutdown) else $error("clock error without shutdown");
	a_sticky_blocks_up: assert property (clock_error_sticky_flag && device_shutdown |=>
		device_shutdown) else $error("restart while sticky flag set");
	a_reload_on_restart: assert property (memory_reload |->
		!device_shutdown && $past(device_shutdown) && reload_bit_ff) else $error("reload pulse out of place");
endmodule

// file: tb/tb_missing_clock_detector.sv
// Self-checking bench for the missing clock detector
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_missing_clock_detector;
	import mcd_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [4:0] mon_clk = 5'h00;
	logic mon_run = 1'b1;
	logic [3:0] ctl = 4'h0;
	logic dens_pwr, bits_pwr, sticky, shut, reload;
	int fails = 0;
	int checked = 0;
	mcd_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_audio_clock(mon_clk[0]),
		.density_modulated_clock(mon_clk[1]), .playback_mod_clock(mon_clk[2]), .sense_mod_clock(mon_clk[3]),
		.pll_clock(mon_clk[4]), .user_power_down(ctl[3]), .other_fault(ctl[2]), .error_flag_clear(ctl[1]),
		.power_up_req(ctl[0]), .density_divider_power(dens_pwr), .bitstream_divider_power(bits_pwr),
		.clock_error_sticky_flag(sticky), .device_shutdown(shut), .memory_reload(reload));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	// Monitored clocks toggle every 7 cycles while mon_run is set
	initial begin
		forever begin
			repeat (7) @(posedge core_clk);
			#1 mon_clk = mon_run ? ~mon_clk : mon_clk;
		end
	end
	task automatic summarize();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc();
		@(posedge core_clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		reg_wr = w;
		reg_rd = ~w;
		reg_addr = a;
		reg_wdata = d;
		cyc();
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cyc();
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic pulse(input logic [3:0] v);
		ctl = v;
		cyc();
		ctl = 4'h0;
		cyc();
	endtask
	task automatic t_reset();
		rdchk(MCD_ADDR_DENSITY_DIV, MCD_RST_DENSITY_DIV);
		rdchk(MCD_ADDR_BITSTREAM_DIV, MCD_RST_BITSTREAM_DIV);
		rdchk(MCD_ADDR_DETECT_CFG, MCD_RST_DETECT_CFG);
		rdchk(MCD_ADDR_TIMEOUT_CFG, MCD_RST_TIMEOUT_CFG);
		rdchk(8'h20, 8'h00);
		`CHK(dens_pwr, 1'b0)
	endtask
	task automatic t_dividers();
		logic [7:0] q, v;
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'h08 : 8'h88;
			bus(1'b1, MCD_ADDR_DENSITY_DIV, v, q);
			bus(1'b1, MCD_ADDR_BITSTREAM_DIV, v ^ 8'h80, q);
			`CHK(dens_pwr, v[7])
			`CHK(bits_pwr, ~v[7])
			rdchk(MCD_ADDR_BITSTREAM_DIV, v ^ 8'h80);
		end
	endtask
	task automatic t_fields();
		logic [7:0] q, v;
		for (int i = 0; i < 8; i++) begin
			v = {3'h0, i[2], i[1:0], 2'b00};
			bus(1'b1, MCD_ADDR_DETECT_CFG, v, q);
			rdchk(MCD_ADDR_DETECT_CFG, v);
			v = {2'b00, i[2:0], 3'h7 - i[2:0]};
			bus(1'b1, MCD_ADDR_TIMEOUT_CFG, v, q);
			rdchk(MCD_ADDR_TIMEOUT_CFG, v);
		end
	endtask
	task automatic t_restart(input logic [7:0] cfg, input logic [3:0] cause, input logic exp);
		logic seen;
		logic [7:0] q;
		seen = 1'b0;
		bus(1'b1, MCD_ADDR_DETECT_CFG, cfg, q);
		pulse(cause);
		repeat (4) cyc();
		`CHK(shut, 1'b1)
		// Clear and restart in one cycle must be ignored
		pulse(4'h3);
		`CHK(shut, 1'b1)
		`CHK(sticky, 1'b0)
		pulse(4'h1);
		for (int i = 0; i < 8; i++) begin
			seen = seen | reload;
			cyc();
		end
		`CHK(seen, exp)
		`CHK(shut, 1'b0)
	endtask
	task automatic t_absence();
		logic [7:0] q;
		pulse(4'h2);
		bus(1'b1, MCD_ADDR_TIMEOUT_CFG, 8'h00, q);
		bus(1'b1, MCD_ADDR_DETECT_CFG, 8'h13, q);
		// Shortest timeout lies beyond the run budget; only early firing can be caught
		mon_run = 1'b0;
		repeat (20000) cyc();
		`CHK(shut, 1'b0)
		`CHK(sticky, 1'b0)
		mon_run = 1'b1;
		repeat (10000) cyc();
		`CHK(shut, 1'b0)
		`CHK(sticky, 1'b0)
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1 rst_b = 1'b1;
		t_reset();
		t_dividers();
		t_fields();
		t_restart(8'h80, 4'h4, 1'b1);
		t_restart(8'h80, 4'h8, 1'b0);
		t_restart(8'h00, 4'h4, 1'b0);
		t_absence();
		summarize();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		fails++;
		summarize();
	end
endmodule
bind mcd_top mcd_top_checker u_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .error_flag_clear(error_flag_clear),
	.density_divider_power(density_divider_power), .bitstream_divider_power(bitstream_divider_power),
	.clock_error_sticky_flag(clock_error_sticky_flag), .device_shutdown(device_shutdown),
	.memory_reload(memory_reload));
